// ==== hdl/rcs_pkg.sv ====
// Package for the reset cause and control register block
package rcs_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // Word offsets of the registers
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h1;
  localparam logic [3:0] IRQ_MASK_OFS = 4'h2;

  // Field positions of the reset cause and control word
  localparam int unsigned TRAP_BIT = 15;
  localparam int unsigned ILLOP_BIT = 14;
  localparam int unsigned FLASH_REG_BIT = 11;
  localparam int unsigned CFGMIS_BIT = 9;
  localparam int unsigned MAIN_REG_BIT = 8;
  localparam int unsigned EXTPIN_BIT = 7;
  localparam int unsigned RSTINS_BIT = 6;
  localparam int unsigned WDT_EN_BIT = 5;
  localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  // Plain storage field at the bottom of the word, bits 3:0
  localparam int unsigned LOW_W = 4;

  // Writable bits: 13, 12 and 10 are not implemented
  localparam logic [15:0] CTRL_WMASK = 16'hCBFF;
  localparam logic [15:0] CTRL_RST = 16'h0003;
  // Bits that hardware reset sources set
  localparam logic [15:0] CAUSE_MASK = 16'hC2D0;

  // Interrupt status and mask layout: one bit per reset cause
  localparam int unsigned IRQ_W = 6;
  localparam logic [5:0] IRQ_RST = 6'h00;

  typedef struct packed {
    logic trap_conflict;
    logic illegal_op;
    logic config_mismatch;
    logic external_pin;
    logic reset_instr;
    logic watchdog_timeout;
  } rcs_cause_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rcs_bus_req_t;

endpackage

// ==== hdl/rcs_reset_cause.sv ====
// Reset cause and control register with cause interrupt
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module rcs_reset_cause
  import rcs_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire rcs_cause_t        cause_i,
  input  wire logic              watchdog_fuse_enable_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   watchdog_run_o,
  output logic                   flash_regulator_sleep_active_o,
  output logic                   main_regulator_sleep_active_o,
  output logic                   irq_o
);

  localparam rcs_cause_t STAT_INIT = rcs_cause_t'(IRQ_RST);

  logic [DATA_W-1:0] ctrl_word;
  logic              trap_flag_q;
  logic              illop_flag_q;
  logic              cfgmis_flag_q;
  logic              extpin_flag_q;
  logic              rstins_flag_q;
  logic              watchdog_timeout_flag_flag_q;
  logic              flash_sel_q;
  logic              main_sel_q;
  logic              wdt_en_q;
  logic [LOW_W-1:0]  low_bits_q;
  logic              trap_stat_q;
  logic              illop_stat_q;
  logic              cfgmis_stat_q;
  logic              extpin_stat_q;
  logic              rstins_stat_q;
  logic              watchdog_timeout_flag_stat_q;
  rcs_cause_t        stat_vec;
  rcs_cause_t        clr_bits;
  logic [IRQ_W-1:0]  mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_mask;

  // Word address decode, shared by the write strobes
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // sticky until cleared
  // A hardware cause beats a software clear in the same cycle
  function automatic logic flag_next(input logic cur,
                                     input logic wr,
                                     input logic wbit,
                                     input logic set);
    logic nxt;
    nxt = wr ? wbit : cur;
    return nxt | set;
  endfunction

  // Write one to clear; a new cause in the same cycle wins
  function automatic logic stat_next(input logic cur,
                                     input logic wr,
                                     input logic wbit,
                                     input logic set);
    logic nxt;
    nxt = (wr && wbit) ? 1'b0 : cur;
    return nxt | set;
  endfunction

  assign wr_ctrl  = reg_wr_i && addr_hit(reg_addr_i, CTRL_OFS);
  assign wr_stat  = reg_wr_i && addr_hit(reg_addr_i, IRQ_STAT_OFS);
  assign wr_mask  = reg_wr_i && addr_hit(reg_addr_i, IRQ_MASK_OFS);
  assign clr_bits = rcs_cause_t'(reg_wdata_i[IRQ_W-1:0]);

  always_comb begin
    ctrl_word                = '0;
    ctrl_word[TRAP_BIT]      = trap_flag_q;
    ctrl_word[ILLOP_BIT]     = illop_flag_q;
    ctrl_word[FLASH_REG_BIT] = flash_sel_q;
    ctrl_word[CFGMIS_BIT]    = cfgmis_flag_q;
    ctrl_word[MAIN_REG_BIT]  = main_sel_q;
    ctrl_word[EXTPIN_BIT]    = extpin_flag_q;
    ctrl_word[RSTINS_BIT]    = rstins_flag_q;
    ctrl_word[WDT_EN_BIT]    = wdt_en_q;
    ctrl_word[WATCHDOG_TIMEOUT_FLAG_BIT]      = watchdog_timeout_flag_flag_q;
    ctrl_word[LOW_W-1:0]     = low_bits_q;
  end

  assign stat_vec = {trap_stat_q, illop_stat_q, cfgmis_stat_q,
                     extpin_stat_q, rstins_stat_q, watchdog_timeout_flag_stat_q};

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trap_flag_q <= CTRL_RST[TRAP_BIT];
    end else begin
      trap_flag_q <= flag_next(trap_flag_q, wr_ctrl,
                               reg_wdata_i[TRAP_BIT],
                               cause_i.trap_conflict);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      illop_flag_q <= CTRL_RST[ILLOP_BIT];
    end else begin
      illop_flag_q <= flag_next(illop_flag_q, wr_ctrl,
                                reg_wdata_i[ILLOP_BIT],
                                cause_i.illegal_op);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfgmis_flag_q <= CTRL_RST[CFGMIS_BIT];
    end else begin
      cfgmis_flag_q <= flag_next(cfgmis_flag_q, wr_ctrl,
                                 reg_wdata_i[CFGMIS_BIT],
                                 cause_i.config_mismatch);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      extpin_flag_q <= CTRL_RST[EXTPIN_BIT];
    end else begin
      extpin_flag_q <= flag_next(extpin_flag_q, wr_ctrl,
                                 reg_wdata_i[EXTPIN_BIT],
                                 cause_i.external_pin);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rstins_flag_q <= CTRL_RST[RSTINS_BIT];
    end else begin
      rstins_flag_q <= flag_next(rstins_flag_q, wr_ctrl,
                                 reg_wdata_i[RSTINS_BIT],
                                 cause_i.reset_instr);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      watchdog_timeout_flag_flag_q <= CTRL_RST[WATCHDOG_TIMEOUT_FLAG_BIT];
    end else begin
      watchdog_timeout_flag_flag_q <= flag_next(watchdog_timeout_flag_flag_q, wr_ctrl,
                               reg_wdata_i[WATCHDOG_TIMEOUT_FLAG_BIT],
                               cause_i.watchdog_timeout);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      flash_sel_q <= CTRL_RST[FLASH_REG_BIT];
    end else if (wr_ctrl) begin
      flash_sel_q <= reg_wdata_i[FLASH_REG_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      main_sel_q <= CTRL_RST[MAIN_REG_BIT];
    end else if (wr_ctrl) begin
      main_sel_q <= reg_wdata_i[MAIN_REG_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wdt_en_q <= CTRL_RST[WDT_EN_BIT];
    end else if (wr_ctrl) begin
      wdt_en_q <= reg_wdata_i[WDT_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      low_bits_q <= CTRL_RST[LOW_W-1:0];
    end else if (wr_ctrl) begin
      low_bits_q <= reg_wdata_i[LOW_W-1:0];
    end
  end

  // Interrupt status, one bit per cause, same order as the cause struct
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trap_stat_q <= STAT_INIT.trap_conflict;
    end else begin
      trap_stat_q <= stat_next(trap_stat_q, wr_stat,
                               clr_bits.trap_conflict,
                               cause_i.trap_conflict);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      illop_stat_q <= STAT_INIT.illegal_op;
    end else begin
      illop_stat_q <= stat_next(illop_stat_q, wr_stat,
                                clr_bits.illegal_op,
                                cause_i.illegal_op);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfgmis_stat_q <= STAT_INIT.config_mismatch;
    end else begin
      cfgmis_stat_q <= stat_next(cfgmis_stat_q, wr_stat,
                                 clr_bits.config_mismatch,
                                 cause_i.config_mismatch);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      extpin_stat_q <= STAT_INIT.external_pin;
    end else begin
      extpin_stat_q <= stat_next(extpin_stat_q, wr_stat,
                                 clr_bits.external_pin,
                                 cause_i.external_pin);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rstins_stat_q <= STAT_INIT.reset_instr;
    end else begin
      rstins_stat_q <= stat_next(rstins_stat_q, wr_stat,
                                 clr_bits.reset_instr,
                                 cause_i.reset_instr);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      watchdog_timeout_flag_stat_q <= STAT_INIT.watchdog_timeout;
    end else begin
      watchdog_timeout_flag_stat_q <= stat_next(watchdog_timeout_flag_stat_q, wr_stat,
                               clr_bits.watchdog_timeout,
                               cause_i.watchdog_timeout);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mask_q <= IRQ_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata_i[IRQ_W-1:0];
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        CTRL_OFS:     rdata_q <= ctrl_word;
        IRQ_STAT_OFS: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, stat_vec};
        IRQ_MASK_OFS: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, mask_q};
        default:      rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = |(stat_vec & mask_q);

  assign watchdog_run_o = watchdog_fuse_enable_i | wdt_en_q;
  assign flash_regulator_sleep_active_o = flash_sel_q;
  assign main_regulator_sleep_active_o = main_sel_q;

endmodule

// ==== testbench/rcs_reset_cause_asserts.sv ====
// Checker for the reset cause register ports
`timescale 1ns/1ps
module rcs_reset_cause_asserts
  import rcs_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire rcs_cause_t        cause_i,
  input wire logic              watchdog_fuse_enable_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              watchdog_run_o,
  input wire logic              flash_regulator_sleep_active_o,
  input wire logic              main_regulator_sleep_active_o,
  input wire logic              irq_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic cw;
  logic cr;
  assign cw = reg_wr_i && reg_addr_i == CTRL_OFS;
  assign cr = reg_rd_i && reg_addr_i == CTRL_OFS;
  a_unimpl_zero: assert property (
    reg_rd_i |=> reg_rdata_o[13:12] == 2'h0) else $error("bits 13:12");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("rdata idle");
  a_fuse_run: assert property (
    watchdog_fuse_enable_i |-> watchdog_run_o) else $error("fuse run");
  a_soft_run: assert property (
    cw && !watchdog_fuse_enable_i ##1 !watchdog_fuse_enable_i
    |-> watchdog_run_o == $past(reg_wdata_i[5])) else $error("soft run");
  a_flash_sel: assert property (
    cw |=> flash_regulator_sleep_active_o == $past(reg_wdata_i[11]))
    else $error("flash sel");
  a_main_sel: assert property (
    cw |=> main_regulator_sleep_active_o == $past(reg_wdata_i[8]))
    else $error("main sel");
  a_trap_flag: assert property (
    cause_i.trap_conflict ##1 cr |=> reg_rdata_o[TRAP_BIT])
    else $error("trap flag");
  a_watchdog_timeout_flag_flag: assert property (
    cause_i.watchdog_timeout ##1 cr |=> reg_rdata_o[WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("watchdog_timeout_flag flag");
  c_irq: cover property (irq_o);
  c_fuse: cover property (watchdog_fuse_enable_i);
  c_trap: cover property (cause_i.trap_conflict);
endmodule

// ==== testbench/rcs_reset_cause_tb.sv ====
// Self-checking testbench for the reset cause register block
`timescale 1ns/1ps
module rcs_reset_cause_tb
  import rcs_pkg::*;
;
  logic clk = 0, rst = 1, wr = 0, rd = 0, fuse = 0, run, fla, mai, irq;
  logic [3:0]  addr = '0;
  logic [15:0] wd = '0, rdat, ex;
  rcs_cause_t  cause = '0;
  int          fails = 0, n_tests = 0;
  int          map [6] = '{4, 6, 7, 9, 14, 15};
  rcs_reset_cause DUT (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .cause_i(cause),
    .watchdog_fuse_enable_i(fuse), .reg_rdata_o(rdat), .watchdog_run_o(run),
    .flash_regulator_sleep_active_o(fla),
    .main_regulator_sleep_active_o(mai), .irq_o(irq));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrt(logic [3:0] a, logic [15:0] d);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rdc(logic [3:0] a, logic [15:0] e);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", e, rdat);
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rdc(CTRL_OFS, 16'h0003);
    wrt(CTRL_OFS, 16'hFFFF);
    rdc(CTRL_OFS, 16'hCBFF);
    chk("flash", 1, 16'(fla));
    chk("main", 1, 16'(mai));
    chk("run", 1, 16'(run));
    wrt(CTRL_OFS, 16'h0000);
    rdc(CTRL_OFS, 16'h0000);
    chk("run", 0, 16'(run));
    chk("flash", 0, 16'(fla));
    chk("main", 0, 16'(mai));
    fuse <= 1;
    @(posedge clk);
    #1 chk("run", 1, 16'(run));
    @(posedge clk);
    fuse <= 0;
    wrt(IRQ_MASK_OFS, 16'h003F);
    ex = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      cause <= rcs_cause_t'(6'h01 << i);
      @(posedge clk);
      cause <= '0;
      ex[map[i]] = 1'b1;
      rdc(CTRL_OFS, ex);
      rdc(IRQ_STAT_OFS, 16'h003F >> (5 - i));
      chk("irq", 1, 16'(irq));
    end
    wrt(IRQ_MASK_OFS, 16'h0000);
    #1 chk("irq", 0, 16'(irq));
    @(posedge clk);
    wrt(IRQ_MASK_OFS, 16'h003F);
    wrt(IRQ_STAT_OFS, 16'h003F);
    #1 chk("irq", 0, 16'(irq));
    @(posedge clk);
    rdc(IRQ_STAT_OFS, 16'h0000);
    rdc(CTRL_OFS, ex);
    rdc(4'hF, 16'h0000);
    finish_test();
  end
endmodule
bind rcs_reset_cause rcs_reset_cause_asserts u_chk (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .cause_i(cause_i),
  .watchdog_fuse_enable_i(watchdog_fuse_enable_i), .irq_o(irq_o),
  .reg_rdata_o(reg_rdata_o), .watchdog_run_o(watchdog_run_o),
  .flash_regulator_sleep_active_o(flash_regulator_sleep_active_o),
  .main_regulator_sleep_active_o(main_regulator_sleep_active_o));
